// >>> verilog/rsc_pkg.sv
// Constants, register map and state codes of the reset source combiner
package rsc_pkg;
    // Register offsets on the plain register port
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_FLAGS = 4'h0;
    localparam logic [3:0] OFS_OSC = 4'h4;
    localparam logic [3:0] OFS_STAT = 4'h8;
    // Reset-cause flag positions
    localparam int B_TRAP = 15;
    localparam int B_ILLOP = 14;
    localparam int B_CFGMM = 9;
    localparam int B_FBIAS = 8;
    localparam int B_PIN = 7;
    localparam int B_SWR = 6;
    localparam int B_WDEN = 5;
    localparam int B_WATCHDOG_TIMEOUT_FLAG = 4;
    localparam int B_SLEEP = 3;
    localparam int B_IDLE = 2;
    localparam int B_BOR = 1;
    localparam int B_POR = 0;
    localparam int OSC_LSB = 12;
    // Power-up value and implemented bits of the flag word
    localparam logic [15:0] FLAGS_POR_VAL = 16'h0003;
    localparam logic [15:0] FLAGS_MASK = 16'hc3ff;
    localparam logic [2:0] OSC_RST_VAL = 3'h0;
    // Timing, figures in their own units
    localparam int CLK_MHZ = 100;
    localparam int T_POR_US = 10;
    localparam int T_RST_US = 10;
    localparam int T_POWER_UP_TIMER_MS = 64;
    localparam int T_POWER_UP_TIMER_REG_US = 10;
    localparam int T_FAIL_SAFE_CLOCK_MONITOR_US = 5;
    localparam int OST_PERIODS = 1024;
    localparam int POR_CYC = T_POR_US * CLK_MHZ;
    localparam int RST_CYC = T_RST_US * CLK_MHZ;
    localparam int POWER_UP_TIMER_CYC = T_POWER_UP_TIMER_MS * 1000 * CLK_MHZ;
    localparam int POWER_UP_TIMER_REG_CYC = T_POWER_UP_TIMER_REG_US * CLK_MHZ;
    localparam int FAIL_SAFE_CLOCK_MONITOR_CYC = T_FAIL_SAFE_CLOCK_MONITOR_US * CLK_MHZ;
    localparam int DLY_W = 23;
    localparam logic [9:0] OST_LAST = 10'(OST_PERIODS - 1);
    // Sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_POR = 4'h1,
        ST_POWER_UP_TIMER = 4'h2,
        ST_RST = 4'h4,
        ST_RUN = 4'h8
    } rsc_state_e;
endpackage

// >>> verilog/rsc_reset_combiner.sv
// Reset source combiner: merges reset sources, records causes, sequences release
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module rsc_reset_combiner #(
    parameter int POWER_UP_TIMER_CYCLES = rsc_pkg::POWER_UP_TIMER_CYC
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic external_pin_reset,
    input wire logic brownout_reset,
    input wire logic software_reset,
    input wire logic watchdog_timeout,
    input wire logic config_mismatch,
    input wire logic trap_conflict,
    input wire logic illegal_opcode,
    input wire logic uninit_wreg_reset,
    input wire logic power_save_sleep,
    input wire logic power_save_idle,
    input wire logic watchdog_clear_instr,
    input wire logic watchdog_fuse_enable,
    input wire logic clock_switch_en,
    input wire logic [2:0] initial_osc_select,
    input wire logic regulator_disabled,
    input wire logic osc_pin,
    input wire logic pll_used,
    input wire logic pll_lock,
    output logic master_reset_out,
    output logic cpu_run,
    output logic osc_clk_release,
    output logic fail_safe_clock_monitor_active,
    output logic watchdog_enable,
    output logic flash_bias_in_sleep,
    output logic regulator_standby_sleep,
    output logic [2:0] current_osc_field
);

    // Pin inputs: two flops before use
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic osc_prev_reg;
    wire logic [3:0] pins = {pll_lock, osc_pin, brownout_reset, external_pin_reset};

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            osc_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            osc_prev_reg <= sync2_reg[2];
        end
    end

    wire logic pin_s = sync2_reg[0];
    wire logic bor_s = sync2_reg[1];
    wire logic osc_rise = sync2_reg[2] & ~osc_prev_reg;
    wire logic lock_s = sync2_reg[3];

    // Non-power reset sources
    wire logic any_rst = pin_s | software_reset | watchdog_timeout | config_mismatch
        | trap_conflict | illegal_opcode | uninit_wreg_reset;

    // Register decode
    wire logic wr_flags = reg_wr & (reg_addr == rsc_pkg::OFS_FLAGS);
    wire logic rd_flags = reg_rd & (reg_addr == rsc_pkg::OFS_FLAGS);
    wire logic rd_osc = reg_rd & (reg_addr == rsc_pkg::OFS_OSC);
    wire logic rd_stat = reg_rd & (reg_addr == rsc_pkg::OFS_STAT);

    // Sequencer state and delay counter
    rsc_pkg::rsc_state_e state_reg;
    rsc_pkg::rsc_state_e state_next;
    logic [rsc_pkg::DLY_W-1:0] dly_reg;
    logic [rsc_pkg::DLY_W-1:0] dly_next;
    wire logic dly_done = (dly_reg == '0);

    // Load values are one less than the delay, since zero ends it
    // power-up timer length
    wire logic [rsc_pkg::DLY_W-1:0] power_up_timer_load = regulator_disabled
        ? rsc_pkg::DLY_W'(POWER_UP_TIMER_CYCLES - 1)
        : rsc_pkg::DLY_W'(rsc_pkg::POWER_UP_TIMER_REG_CYC - 1);
    wire logic [rsc_pkg::DLY_W-1:0] rst_load = rsc_pkg::DLY_W'(rsc_pkg::RST_CYC - 1);

    // Next state of the release sequencer
    always_comb begin
        state_next = state_reg;
        dly_next = dly_done ? dly_reg : dly_reg - 1'b1;
        case (state_reg)
            rsc_pkg::ST_POR: begin
                if (dly_done) begin
                    state_next = rsc_pkg::ST_POWER_UP_TIMER;
                    dly_next = power_up_timer_load;
                end
            end
            rsc_pkg::ST_POWER_UP_TIMER: begin
                if (bor_s) begin
                    dly_next = power_up_timer_load;
                end else if (dly_done) begin
                    state_next = rsc_pkg::ST_RST;
                    dly_next = rst_load;
                end
            end
            rsc_pkg::ST_RST: begin
                if (bor_s) begin
                    state_next = rsc_pkg::ST_POWER_UP_TIMER;
                    dly_next = power_up_timer_load;
                end else if (any_rst) begin
                    dly_next = rst_load;
                end else if (dly_done) begin
                    state_next = rsc_pkg::ST_RUN;
                end
            end
            rsc_pkg::ST_RUN: begin
                if (bor_s) begin
                    state_next = rsc_pkg::ST_POWER_UP_TIMER;
                    dly_next = power_up_timer_load;
                end else if (any_rst) begin
                    state_next = rsc_pkg::ST_RST;
                    dly_next = rst_load;
                end
            end
            default: begin
                state_next = rsc_pkg::ST_POR;
                dly_next = rsc_pkg::DLY_W'(rsc_pkg::POR_CYC - 1);
            end
        endcase
    end

    // Sequencer flops; master reset is active until run
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= rsc_pkg::ST_POR;
            dly_reg <= rsc_pkg::DLY_W'(rsc_pkg::POR_CYC - 1);
            master_reset_out <= 1'b1;
        end else begin
            state_reg <= state_next;
            dly_reg <= dly_next;
            master_reset_out <= (state_next != rsc_pkg::ST_RUN);
        end
    end

    // Reset-cause flags: software write, then hardware clears, then sets
    logic [15:0] flags_reg;
    logic [15:0] flags_next;
    logic [15:0] flags_set;

    // every active source sets its bit; illegal opcode and uninitialised W register share B_ILLOP
    always_comb begin
        flags_set = 16'h0000;
        flags_set[rsc_pkg::B_TRAP] = trap_conflict;
        flags_set[rsc_pkg::B_ILLOP] = illegal_opcode | uninit_wreg_reset;
        flags_set[rsc_pkg::B_CFGMM] = config_mismatch;
        flags_set[rsc_pkg::B_PIN] = pin_s;
        flags_set[rsc_pkg::B_SWR] = software_reset;
        flags_set[rsc_pkg::B_WATCHDOG_TIMEOUT_FLAG] = watchdog_timeout;
        flags_set[rsc_pkg::B_SLEEP] = power_save_sleep;
        flags_set[rsc_pkg::B_IDLE] = power_save_idle;
        flags_set[rsc_pkg::B_BOR] = bor_s;
    end

    // instruction clear of the timeout, set wins
    always_comb begin
        flags_next = wr_flags ? reg_wdata : flags_reg;
        if (power_save_sleep | power_save_idle | watchdog_clear_instr) begin
            flags_next[rsc_pkg::B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
        end
        flags_next = (flags_next | flags_set) & rsc_pkg::FLAGS_MASK;
    end

    // bit 0 set only by this reset value or by a software write
    // power-up value; control bits kept over other resets
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flags_reg <= rsc_pkg::FLAGS_POR_VAL;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // watchdog enable; flash bias in sleep
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            watchdog_enable <= 1'b0;
            flash_bias_in_sleep <= 1'b0;
            regulator_standby_sleep <= 1'b1;
        end else begin
            watchdog_enable <= watchdog_fuse_enable | flags_next[rsc_pkg::B_WDEN];
            flash_bias_in_sleep <= flags_next[rsc_pkg::B_FBIAS];
            regulator_standby_sleep <= ~flags_next[rsc_pkg::B_FBIAS];
        end
    end

    // Clock selection after reset
    wire logic power_reset = (state_reg == rsc_pkg::ST_POR) | (state_reg == rsc_pkg::ST_POWER_UP_TIMER);
    wire logic other_reset = (state_reg == rsc_pkg::ST_RST);

    // no switching: follow config on any reset
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            current_osc_field <= rsc_pkg::OSC_RST_VAL;
        end else if (power_reset | (other_reset & ~clock_switch_en)) begin
            current_osc_field <= initial_osc_select;
        end
    end

    // Oscillator start-up timer, restarted by brown-out; power-up restarts it through reset
    logic [9:0] ost_cnt_reg;
    wire logic ost_hit = osc_rise & (ost_cnt_reg == rsc_pkg::OST_LAST);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ost_cnt_reg <= 10'h000;
            osc_clk_release <= 1'b0;
        end else if (bor_s) begin
            ost_cnt_reg <= 10'h000;
            osc_clk_release <= 1'b0;
        end else if (!osc_clk_release & osc_rise) begin
            ost_cnt_reg <= ost_cnt_reg + 10'h001;
            osc_clk_release <= ost_hit;
        end
    end

    // execution waits for release, timer and lock
    wire logic clk_ready = osc_clk_release & (lock_s | ~pll_used);

    // Clock monitor start delay after release
    logic [9:0] fail_safe_clock_monitor_cnt_reg;
    wire logic fail_safe_clock_monitor_due = (fail_safe_clock_monitor_cnt_reg == 10'(rsc_pkg::FAIL_SAFE_CLOCK_MONITOR_CYC - 1));

    // monitor waits for release plus delay
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fail_safe_clock_monitor_cnt_reg <= 10'h000;
            fail_safe_clock_monitor_active <= 1'b0;
            cpu_run <= 1'b0;
        end else begin
            cpu_run <= (state_next == rsc_pkg::ST_RUN) & clk_ready;
            if (state_next != rsc_pkg::ST_RUN || master_reset_out) begin
                fail_safe_clock_monitor_cnt_reg <= 10'h000;
                fail_safe_clock_monitor_active <= 1'b0;
            end else if (!fail_safe_clock_monitor_due) begin
                fail_safe_clock_monitor_cnt_reg <= fail_safe_clock_monitor_cnt_reg + 10'h001;
            end else begin
                fail_safe_clock_monitor_active <= 1'b1;
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads zero
    wire logic [15:0] osc_word = {1'b0, current_osc_field, 12'h000};
    wire logic [15:0] stat_word = {10'h000, fail_safe_clock_monitor_active, clk_ready, state_reg};
    wire logic [15:0] rd_mux = rd_flags ? flags_reg
        : rd_osc ? osc_word
        : rd_stat ? stat_word
        : 16'h0000;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= rd_mux;
        end
    end

    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence seq_src;
        any_rst & ~bor_s;
    endsequence

    sequence seq_hold_rst;
        master_reset_out [*2];
    endsequence

    chk_src_drives_reset: assert property (seq_src |=> seq_hold_rst)
        else $error("source did not hold master reset");

    chk_trap_flag_set: assert property (trap_conflict |=> flags_reg[rsc_pkg::B_TRAP])
        else $error("trap flag not set");

    chk_illop_flag_set: assert property ((illegal_opcode | uninit_wreg_reset)
        |=> flags_reg[rsc_pkg::B_ILLOP])
        else $error("illegal op flag not set");

    chk_pin_flag_set: assert property (pin_s |=> flags_reg[rsc_pkg::B_PIN])
        else $error("pin reset flag not set");

    chk_por_flag_hold: assert property ((~flags_reg[rsc_pkg::B_POR] & ~wr_flags)
        |=> ~flags_reg[rsc_pkg::B_POR])
        else $error("power-up flag set outside power-up");

    chk_multi_flags: assert property ((trap_conflict & config_mismatch & software_reset)
        |=> flags_reg[rsc_pkg::B_TRAP] & flags_reg[rsc_pkg::B_CFGMM]
        & flags_reg[rsc_pkg::B_SWR])
        else $error("simultaneous causes not all flagged");

    chk_watchdog_timeout_flag_clear: assert property ((watchdog_clear_instr & ~watchdog_timeout & ~wr_flags)
        |=> ~flags_reg[rsc_pkg::B_WATCHDOG_TIMEOUT_FLAG])
        else $error("watchdog flag not cleared");

    chk_unimpl_zero: assert property (rd_flags |=> reg_rdata[13:10] == 4'h0)
        else $error("unimplemented bits read nonzero");

    chk_wdog_enable: assert property (watchdog_fuse_enable |=> watchdog_enable)
        else $error("fuse did not force watchdog");

    chk_release_order: assert property ($fell(master_reset_out)
        |-> $past(state_reg, 2) == rsc_pkg::ST_RST)
        else $error("release not after delays");

    chk_run_clock_ok: assert property (cpu_run |-> ~master_reset_out & osc_clk_release)
        else $error("execution before clock ready");

    chk_fail_safe_clock_monitor_start: assert property ($rose(fail_safe_clock_monitor_active) |-> $past(fail_safe_clock_monitor_due) & ~master_reset_out)
        else $error("monitor started early");

    chk_osc_power: assert property ((state_reg == rsc_pkg::ST_POR)
        |=> current_osc_field == $past(initial_osc_select))
        else $error("power reset did not load config clock");

    chk_osc_keep: assert property ((other_reset & clock_switch_en) |=> $stable(current_osc_field))
        else $error("clock field changed on a non-power reset");

    chk_osc_fixed: assert property ((other_reset & ~clock_switch_en)
        |=> current_osc_field == $past(initial_osc_select))
        else $error("fixed clock not taken from config bits");

    chk_ost_count: assert property ($rose(osc_clk_release)
        |-> $past(ost_cnt_reg) == rsc_pkg::OST_LAST)
        else $error("start-up timer count wrong");

endmodule

// >>> verif/rsc_osc_model.sv
// Oscillator and PLL model on the far side of the reset combiner
`timescale 1ns/1ns
module rsc_osc_model #(
    parameter int HALF_NS = 11,
    parameter int LOCK_EDGES = 1100
) (
    input wire logic run,
    output logic osc_pin,
    output logic pll_lock,
    output int edges
);
    // Crystal wave, slower than the regulator-off release delays so start-up really gates execution
    always begin
        #HALF_NS;
        osc_pin = run ? ~osc_pin : 1'b0;
    end
    // Rising edges counted since power came up
    always @(posedge osc_pin or negedge run) begin
        if (!run) begin
            edges <= 0;
        end else begin
            edges <= edges + 1;
        end
    end
    assign pll_lock = (edges >= LOCK_EDGES);
endmodule

// >>> verif/tb_rsc_reset_combiner.sv
// Self-checking bench for the reset source combiner
`timescale 1ns/1ns
module tb_rsc_reset_combiner;
    localparam int PW = 50;
    localparam int RST = rsc_pkg::RST_CYC;
    localparam int REG_ON = rsc_pkg::POR_CYC + rsc_pkg::POWER_UP_TIMER_REG_CYC + rsc_pkg::RST_CYC;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] src = 8'h00;
    logic [2:0] ps = 3'h0;
    logic fuse = 1'b0;
    logic cs_en = 1'b1;
    logic reg_off = 1'b1;
    logic [2:0] osc_sel = 3'h2;
    logic [15:0] reg_rdata, rd, exp_flags;
    logic osc_pin, pll_lock, master_reset_out, cpu_run, osc_clk_release, fail_safe_clock_monitor_active;
    logic watchdog_enable, flash_bias_in_sleep, regulator_standby_sleep;
    logic [2:0] current_osc_field, exp_osc;
    int edges, rel_edges, n, m;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int fbit[8] = '{rsc_pkg::B_SWR, rsc_pkg::B_WATCHDOG_TIMEOUT_FLAG, rsc_pkg::B_CFGMM, rsc_pkg::B_TRAP,
                    rsc_pkg::B_ILLOP, rsc_pkg::B_ILLOP, rsc_pkg::B_PIN, rsc_pkg::B_BOR};

    // Clock and cycle ceiling
    always #5 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            $display("CHECK FAILED at %0t: run timed out", $time);
            wrap_up;
        end
    end
    // Oscillator edge count at the moment the start-up timer lets go
    always @(posedge osc_clk_release) rel_edges = edges;

    rsc_reset_combiner #(.POWER_UP_TIMER_CYCLES(PW)) dut (
        .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .external_pin_reset(src[6]), .brownout_reset(src[7]), .software_reset(src[0]),
        .watchdog_timeout(src[1]), .config_mismatch(src[2]), .trap_conflict(src[3]),
        .illegal_opcode(src[4]), .uninit_wreg_reset(src[5]),
        .power_save_sleep(ps[0]), .power_save_idle(ps[1]), .watchdog_clear_instr(ps[2]),
        .watchdog_fuse_enable(fuse), .clock_switch_en(cs_en), .initial_osc_select(osc_sel),
        .regulator_disabled(reg_off), .osc_pin(osc_pin), .pll_used(1'b1), .pll_lock(pll_lock),
        .master_reset_out(master_reset_out), .cpu_run(cpu_run), .osc_clk_release(osc_clk_release),
        .fail_safe_clock_monitor_active(fail_safe_clock_monitor_active), .watchdog_enable(watchdog_enable),
        .flash_bias_in_sleep(flash_bias_in_sleep), .regulator_standby_sleep(regulator_standby_sleep),
        .current_osc_field(current_osc_field)
    );
    rsc_osc_model osc (.run(arst_n), .osc_pin(osc_pin), .pll_lock(pll_lock), .edges(edges));

    // Comparisons and verdict
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_word({15'h0000, got}, {15'h0000, exp}, what);
    endtask
    task automatic chk_range(input int got, input int lo, input int hi, input string what);
        num_checks++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("CHECK FAILED at %0t: %s count %0d outside %0d..%0d", $time, what, got, lo, hi);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Register port cycles
    task automatic tick;
        @(posedge mclk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Waits for master reset to drop, bounded
    task automatic wait_rel(output int k);
        k = 0;
        while (master_reset_out !== 1'b0 && k < 5000) begin
            tick;
            k++;
        end
    endtask
    // One-cycle source pulse, then reset entry and release timing
    task automatic pulse_src(input logic [7:0] v, input int lo);
        @(posedge mclk);
        src <= v;
        @(posedge mclk);
        src <= 8'h00;
        m = 0;
        while (master_reset_out !== 1'b1 && m < 6) begin
            tick;
            m++;
        end
        chk_bit(master_reset_out, 1'b1, "reset entry");
        chk_bit(cpu_run, 1'b0, "run held in reset");
        wait_rel(n);
        chk_range(n + m, lo - 2, lo + 8, "release delay");
    endtask
    task automatic pulse_ps(input logic [2:0] v);
        @(posedge mclk);
        ps <= v;
        @(posedge mclk);
        ps <= 3'h0;
    endtask

    initial begin
        // Power-up and release sequence
        repeat (12) @(posedge mclk);
        chk_bit(master_reset_out, 1'b1, "reset during power-up");
        arst_n <= 1'b1;
        wait_rel(n);
        chk_range(n, rsc_pkg::POR_CYC + PW + RST - 2, rsc_pkg::POR_CYC + PW + RST + 8, "power-up release");
        chk_bit(cpu_run, 1'b0, "run waits for oscillator");
        rd_reg(rsc_pkg::OFS_FLAGS, rd);
        chk_word(rd, 16'h0003, "power-up flags");
        chk_word({13'h0000, current_osc_field}, 16'h0002, "power-up clock");
        m = 2;
        while (fail_safe_clock_monitor_active !== 1'b1 && m < 700) begin
            tick;
            m++;
        end
        chk_range(m, rsc_pkg::FAIL_SAFE_CLOCK_MONITOR_CYC - 1, rsc_pkg::FAIL_SAFE_CLOCK_MONITOR_CYC + 3, "monitor start");
        while (cpu_run !== 1'b1 && m < 3000) begin
            tick;
            m++;
        end
        chk_bit(cpu_run & osc_clk_release & pll_lock, 1'b1, "run after clock ready");
        chk_range(rel_edges, rsc_pkg::OST_PERIODS, rsc_pkg::OST_PERIODS + 6, "start-up timer");
        // Software writes, unimplemented bits and control bits
        wr_reg(rsc_pkg::OFS_FLAGS, 16'hffff);
        rd_reg(rsc_pkg::OFS_FLAGS, rd);
        chk_word(rd, 16'hc3ff, "all flags written");
        chk_bit(master_reset_out, 1'b0, "no reset from flag write");
        chk_bit(watchdog_enable, 1'b1, "watchdog on");
        chk_bit(flash_bias_in_sleep & ~regulator_standby_sleep, 1'b1, "bias kept");
        wr_reg(rsc_pkg::OFS_FLAGS, 16'h0000);
        rd_reg(rsc_pkg::OFS_FLAGS, rd);
        chk_word(rd, 16'h0000, "flags cleared");
        chk_bit(watchdog_enable | flash_bias_in_sleep | ~regulator_standby_sleep, 1'b0, "off");
        @(posedge mclk);
        fuse <= 1'b1;
        tick;
        chk_bit(watchdog_enable, 1'b1, "fuse forces watchdog");
        @(posedge mclk);
        fuse <= 1'b0;
        // Power-save and watchdog-clear instructions
        for (int i = 0; i < 3; i++) begin
            wr_reg(rsc_pkg::OFS_FLAGS, 16'h0010);
            pulse_ps(3'(1 << i));
            rd_reg(rsc_pkg::OFS_FLAGS, rd);
            chk_word(rd, (i == 2) ? 16'h0000 : 16'(8 >> i), "power-save flags");
        end
        // Every reset source; earlier flags must survive later resets
        wr_reg(rsc_pkg::OFS_FLAGS, 16'h0000);
        exp_flags = 16'h0000;
        exp_osc = 3'h2;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            osc_sel <= 3'(i | 1);
            pulse_src(8'(1 << i), (i == 7) ? RST + PW : RST + ((i == 6) ? 2 : 0));
            exp_flags = exp_flags | 16'(1 << fbit[i]);
            if (i == 7) begin
                exp_osc = 3'(i | 1);
                chk_bit(cpu_run, 1'b0, "run waits for restarted timer");
            end
            rd_reg(rsc_pkg::OFS_FLAGS, rd);
            chk_word(rd, exp_flags, "cause flag");
            chk_word({13'h0000, current_osc_field}, {13'h0000, exp_osc}, "clock after reset");
        end
        // Three sources together
        wr_reg(rsc_pkg::OFS_FLAGS, 16'h0000);
        pulse_src(8'h0d, RST);
        rd_reg(rsc_pkg::OFS_FLAGS, rd);
        chk_word(rd, 16'h8240, "all three causes");
        // Clock switching off follows configuration bits
        @(posedge mclk);
        cs_en <= 1'b0;
        osc_sel <= 3'h6;
        pulse_src(8'h01, RST);
        chk_word({13'h0000, current_osc_field}, 16'h0006, "fixed clock");
        rd_reg(rsc_pkg::OFS_OSC, rd);
        chk_word(rd & 16'h7000, 16'h6000, "oscillator control read");
        rd_reg(rsc_pkg::OFS_STAT, rd);
        chk_word(rd & 16'h000f, 16'h0008, "running state");
        rd_reg(4'hc, rd);
        chk_word(rd, 16'h0000, "unmapped read");
        // Mid-run power-up clears the causes
        wr_reg(rsc_pkg::OFS_FLAGS, 16'hc3ff);
        @(posedge mclk);
        arst_n <= 1'b0;
        reg_off <= 1'b0;
        tick;
        tick;
        chk_bit(master_reset_out, 1'b1, "power-up reset again");
        @(posedge mclk);
        arst_n <= 1'b1;
        rd_reg(rsc_pkg::OFS_FLAGS, rd);
        chk_word(rd, 16'h0003, "flags after power-up");
        wait_rel(n);
        chk_range(n + 2, REG_ON - 2, REG_ON + 8, "regulator-on release");
        wrap_up;
    end
endmodule
